// file: hw/exec_defs.svh
/*
 * Constants of the instruction-subset execution unit: register-port offsets,
 * status bit positions and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

`define ADDR_ACC        7'h00
`define ADDR_STATUS     7'h01
`define ADDR_TMODE      7'h02
`define ADDR_TPTR_HIGH  7'h03
`define ADDR_TDATA_HIGH 7'h04
`define ADDR_SPACE_BIT  6

`define STAT_C          0
`define STAT_DC         1
`define STAT_Z          2

`define ACC_RST         8'h00
`define TMODE_RST       8'h00
`define TPTR_HIGH_RST   8'h00
`define TDATA_HIGH_RST  6'h00
`define ROM_ADDR_RST    11'h000

`endif

// file: hw/exec_pkg.sv
/*
 * Types of the instruction-subset execution unit.
 * Assumes nothing of its surroundings.
 */
package exec_pkg;

    typedef enum logic [2:0] {
        OP_SUB_ACC_FROM_REG = 3'h0,
        OP_NIBBLE_SWAP_REG  = 3'h1,
        OP_ROM_TABLE_READ   = 3'h2,
        OP_TIMER_MODE_READ  = 3'h3,
        OP_TIMER_MODE_WRITE = 3'h4,
        OP_XOR_ACC_REG      = 3'h5,
        OP_XOR_ACC_IMM      = 3'h6,
        OP_NONE             = 3'h7
    } op_e;

    typedef enum logic {
        ST_IDLE     = 1'b0,
        ST_ROM_WAIT = 1'b1
    } exec_state_e;

    typedef struct packed {
        exec_state_e state;
        logic [7:0]  acc;
        logic [7:0]  tmode;
        logic [7:0]  tptr_high;
        logic [5:0]  tdata_high;
        logic        z;
        logic        dc;
        logic        c;
        logic [10:0] rom_addr;
        logic [7:0]  rdata;
    } exec_s;

endpackage : exec_pkg

// file: hw/reg_space.sv
/*
 * General register space: one write port, two combinational read ports.
 * Assumes the caller arbitrates between its writers.
 */
`timescale 1ns/100ps

module reg_space
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64,
    parameter int AW    = 6
)
(
    input  wire logic             ref_clk,  // core clock
    input  wire logic             rst,      // sync reset, high
    input  wire logic             we,       // write enable
    input  wire logic [AW-1:0]    waddr,    // write index
    input  wire logic [WIDTH-1:0] wdata,    // write data
    input  wire logic [AW-1:0]    raddr_a,  // operand read index
    output logic      [WIDTH-1:0] rdata_a,  // operand read data
    input  wire logic [AW-1:0]    raddr_b,  // port read index
    output logic      [WIDTH-1:0] rdata_b   // port read data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } space_s;

    space_s s_r;
    space_s s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (we)
        begin
            s_nxt.mem[waddr] = wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign rdata_a = s_r.mem[raddr_a];
    assign rdata_b = s_r.mem[raddr_b];

endmodule : reg_space

// file: hw/exec_unit.sv
/*
 * Execution unit for a subset of an 8-bit core: subtract, nibble swap,
 * ROM table read, timer-mode moves and exclusive-OR.
 * Assumes a combinational program ROM answering rom_addr in the same cycle,
 * and a controller that issues one op at a time with op_valid/op_ready.
 */
// Decided for this implementation: the placing of the registers and the plain strobed port.
// What this block does
// - register minus accumulator, two's complement, sets Z, DC, C; index 0..63.
// - destination bit 0 writes accumulator, 1 writes the addressed register.
// - swap puts operand low nibble high and high nibble low; flags kept.
// - table read addresses ROM with pointer-high bits 2..0 and accumulator; low byte to acc.
// - table read puts ROM word bits 13..8 into table-data-high bits 5..0; flags kept.
// - timer-mode read copies timer-mode register to accumulator, flags kept.
// - timer-mode write loads accumulator into timer-mode register, flags kept.
// - register XOR writes acc xor register to chosen destination, only Z changes.
// - immediate XOR writes acc xor immediate to accumulator, only Z changes.
`timescale 1ns/100ps
`include "exec_defs.svh"

module exec_unit
    import exec_pkg::*;
#(
    parameter int RAW = 6
)
(
    input  wire logic          ref_clk,     // core clock, 10 MHz
    input  wire logic          rst,         // sync reset, high
    input  wire logic          op_valid,    // op offered
    output logic               op_ready,    // op accepted this cycle
    input  wire op_e           op_kind,     // which op
    input  wire logic [RAW-1:0] op_index,   // register operand index
    input  wire logic          op_dest,     // 0 acc, 1 register
    input  wire logic [7:0]    op_imm,      // immediate operand
    output logic      [10:0]   rom_addr,    // program ROM address
    input  wire logic [13:0]   rom_data,    // program ROM word
    input  wire logic [6:0]    bus_addr,    // register port address
    input  wire logic [7:0]    bus_wdata,   // register port write data
    input  wire logic          bus_wr,      // write strobe
    input  wire logic          bus_rd,      // read strobe
    output logic      [7:0]    bus_rdata,   // read data, cycle after strobe
    output logic      [7:0]    tmode_out    // timer-mode register to timer
);

    exec_s s_r;
    exec_s s_nxt;

    logic [7:0]     opnd;
    logic [7:0]     bus_reg_data;
    logic           exec_we;
    logic [7:0]     exec_wdata;
    logic           reg_we;
    logic [RAW-1:0] reg_waddr;
    logic [7:0]     reg_wdata;
    logic [8:0]     sub_sum;
    logic [4:0]     sub_low;
    logic           taken;
    logic           bus_space;

    assign bus_space = bus_addr[`ADDR_SPACE_BIT];
    assign op_ready  = (s_r.state == ST_IDLE);
    assign taken     = op_valid && op_ready;

    // r + ~acc + 1; carry out means no borrow
    assign sub_sum = {1'b0, opnd} + {1'b0, ~s_r.acc} + 9'h001;
    assign sub_low = {1'b0, opnd[3:0]} + {1'b0, ~s_r.acc[3:0]} + 5'h01;

    reg_space #(
        .WIDTH (8),
        .DEPTH (64),
        .AW    (RAW)
    ) u_space (
        .ref_clk (ref_clk),
        .rst     (rst),
        .we      (reg_we),
        .waddr   (reg_waddr),
        .wdata   (reg_wdata),
        .raddr_a (op_index),
        .rdata_a (opnd),
        .raddr_b (bus_addr[RAW-1:0]),
        .rdata_b (bus_reg_data)
    );

    // execution write wins over a port write in the same cycle
    assign reg_we    = exec_we || (bus_wr && bus_space);
    assign reg_waddr = exec_we ? op_index : bus_addr[RAW-1:0];
    assign reg_wdata = exec_we ? exec_wdata : bus_wdata;

    always_comb
    begin
        s_nxt      = s_r;
        exec_we    = 1'b0;
        exec_wdata = 8'h00;
        s_nxt.rdata = 8'h00;
        if (bus_rd)
        begin
            if (bus_space)
            begin
                s_nxt.rdata = bus_reg_data;
            end
            else
            begin
                unique case (bus_addr)
                    `ADDR_ACC:        s_nxt.rdata = s_r.acc;
                    `ADDR_STATUS:     s_nxt.rdata = {5'h00, s_r.z, s_r.dc, s_r.c};
                    `ADDR_TMODE:      s_nxt.rdata = s_r.tmode;
                    `ADDR_TPTR_HIGH:  s_nxt.rdata = s_r.tptr_high;
                    `ADDR_TDATA_HIGH: s_nxt.rdata = {2'h0, s_r.tdata_high};
                    default:          s_nxt.rdata = 8'h00;
                endcase
            end
        end
        if (bus_wr && !bus_space)
        begin
            unique case (bus_addr)
                `ADDR_ACC:        s_nxt.acc = bus_wdata;
                `ADDR_STATUS:
                begin
                    s_nxt.c  = bus_wdata[`STAT_C];
                    s_nxt.dc = bus_wdata[`STAT_DC];
                    s_nxt.z  = bus_wdata[`STAT_Z];
                end
                `ADDR_TMODE:      s_nxt.tmode = bus_wdata;
                `ADDR_TPTR_HIGH:  s_nxt.tptr_high = bus_wdata;
                `ADDR_TDATA_HIGH: s_nxt.tdata_high = bus_wdata[5:0];
                default:          ;
            endcase
        end
        unique case (s_r.state)
            ST_IDLE:
            begin
                if (op_valid)
                begin
                    unique case (op_kind)
                        OP_SUB_ACC_FROM_REG:
                        begin
                            exec_wdata = sub_sum[7:0];
                            s_nxt.z    = (sub_sum[7:0] == 8'h00);
                            s_nxt.dc   = sub_low[4];
                            s_nxt.c    = sub_sum[8];
                        end
                        OP_NIBBLE_SWAP_REG:
                        begin
                            exec_wdata = {opnd[3:0], opnd[7:4]};
                        end
                        OP_XOR_ACC_REG:
                        begin
                            exec_wdata = s_r.acc ^ opnd;
                            s_nxt.z    = ((s_r.acc ^ opnd) == 8'h00);
                        end
                        OP_XOR_ACC_IMM:
                        begin
                            s_nxt.acc = s_r.acc ^ op_imm;
                            s_nxt.z   = ((s_r.acc ^ op_imm) == 8'h00);
                        end
                        OP_TIMER_MODE_READ:  s_nxt.acc   = s_r.tmode;
                        OP_TIMER_MODE_WRITE: s_nxt.tmode = s_r.acc;
                        OP_ROM_TABLE_READ:
                        begin
                            s_nxt.rom_addr = {s_r.tptr_high[2:0], s_r.acc};
                            s_nxt.state    = ST_ROM_WAIT;
                        end
                        default:             ;
                    endcase
                    // register-operand ops route by destination bit
                    if (op_kind == OP_SUB_ACC_FROM_REG || op_kind == OP_NIBBLE_SWAP_REG
                        || op_kind == OP_XOR_ACC_REG)
                    begin
                        if (op_dest)
                        begin
                            exec_we = 1'b1;
                        end
                        else
                        begin
                            s_nxt.acc = exec_wdata;
                        end
                    end
                end
            end
            ST_ROM_WAIT:
            begin
                s_nxt.acc        = rom_data[7:0];
                s_nxt.tdata_high = rom_data[13:8];
                s_nxt.state      = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_r.state      <= ST_IDLE;
            s_r.acc        <= `ACC_RST;
            s_r.tmode      <= `TMODE_RST;
            s_r.tptr_high  <= `TPTR_HIGH_RST;
            s_r.tdata_high <= `TDATA_HIGH_RST;
            s_r.z          <= 1'b0;
            s_r.dc         <= 1'b0;
            s_r.c          <= 1'b0;
            s_r.rom_addr   <= `ROM_ADDR_RST;
            s_r.rdata      <= 8'h00;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign rom_addr  = s_r.rom_addr;
    assign bus_rdata = s_r.rdata;
    assign tmode_out = s_r.tmode;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sub_to_acc_a: assert property (
        taken && op_kind == OP_SUB_ACC_FROM_REG && !op_dest && !bus_wr
        |=> s_r.acc == $past(opnd) - $past(s_r.acc)
            && s_r.z == (s_r.acc == 8'h00))
        else $error("subtract result to accumulator wrong");

    sub_carry_a: assert property (
        taken && op_kind == OP_SUB_ACC_FROM_REG && !bus_wr
        |=> s_r.c == ($past(opnd) >= $past(s_r.acc))
            && s_r.dc == ($past(opnd[3:0]) >= $past(s_r.acc[3:0])))
        else $error("subtract carry or digit carry wrong");

    dest_reg_a: assert property (
        taken && op_dest && !bus_wr && (op_kind == OP_SUB_ACC_FROM_REG
            || op_kind == OP_XOR_ACC_REG || op_kind == OP_NIBBLE_SWAP_REG)
        |-> reg_we && reg_waddr == op_index ##1 $stable(s_r.acc))
        else $error("destination bit one must leave accumulator");

    swap_value_a: assert property (
        taken && op_kind == OP_NIBBLE_SWAP_REG && !op_dest && !bus_wr
        |=> s_r.acc == {$past(opnd[3:0]), $past(opnd[7:4])}
            && $stable({s_r.z, s_r.dc, s_r.c}))
        else $error("nibble swap wrong or flags moved");

    table_read_a: assert property (
        taken && op_kind == OP_ROM_TABLE_READ && !bus_wr
        |=> rom_addr == {$past(s_r.tptr_high[2:0]), $past(s_r.acc)}
            ##1 s_r.acc == $past(rom_data[7:0]))
        else $error("table read address or low byte wrong");

    table_high_a: assert property (
        s_r.state == ST_ROM_WAIT && !bus_wr
        |=> s_r.tdata_high == $past(rom_data[13:8]) && $stable({s_r.z, s_r.dc, s_r.c}))
        else $error("table data high wrong or flags moved");

    table_cycles_a: assert property (
        taken && op_kind == OP_ROM_TABLE_READ
        |=> !op_ready ##1 op_ready)
        else $error("table read must take exactly two cycles");

    tm_read_a: assert property (
        taken && op_kind == OP_TIMER_MODE_READ && !bus_wr
        |=> s_r.acc == $past(s_r.tmode) && $stable({s_r.z, s_r.dc, s_r.c}))
        else $error("timer-mode read wrong");

    tm_write_a: assert property (
        taken && op_kind == OP_TIMER_MODE_WRITE && !bus_wr
        |=> tmode_out == $past(s_r.acc) && $stable({s_r.z, s_r.dc, s_r.c}))
        else $error("timer-mode write wrong");

    xor_reg_a: assert property (
        taken && op_kind == OP_XOR_ACC_REG && !op_dest && !bus_wr
        |=> s_r.acc == ($past(s_r.acc) ^ $past(opnd))
            && s_r.z == (s_r.acc == 8'h00) && $stable({s_r.dc, s_r.c}))
        else $error("register xor wrong");

    xor_imm_a: assert property (
        taken && op_kind == OP_XOR_ACC_IMM && !bus_wr
        |=> s_r.acc == ($past(s_r.acc) ^ $past(op_imm))
            && s_r.z == (s_r.acc == 8'h00) && $stable({s_r.dc, s_r.c}))
        else $error("immediate xor wrong");

endmodule : exec_unit

// file: tb/tb.sv
/*
 * Self-checking bench for exec_unit: drives ops and the register port, models the ROM.
 * Assumes the design's own assertions are in its files; a combinational ROM answers rom_addr.
 */
`timescale 1ns/100ps
`include "exec_defs.svh"

module tb;
    import exec_pkg::*;

    logic        ref_clk;
    logic        rst;
    logic        op_valid;
    logic        op_ready;
    op_e         op_kind;
    logic [5:0]  op_index;
    logic        op_dest;
    logic [7:0]  op_imm;
    logic [10:0] rom_addr;
    logic [13:0] rom_data;
    logic [6:0]  bus_addr;
    logic [7:0]  bus_wdata;
    logic        bus_wr;
    logic        bus_rd;
    logic [7:0]  bus_rdata;
    logic [7:0]  tmode_out;
    int          bad_count;
    int          comparisons;

    exec_unit #(.RAW(6)) exec_unit_i
    (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .op_valid  (op_valid),
        .op_ready  (op_ready),
        .op_kind   (op_kind),
        .op_index  (op_index),
        .op_dest   (op_dest),
        .op_imm    (op_imm),
        .rom_addr  (rom_addr),
        .rom_data  (rom_data),
        .bus_addr  (bus_addr),
        .bus_wdata (bus_wdata),
        .bus_wr    (bus_wr),
        .bus_rd    (bus_rd),
        .bus_rdata (bus_rdata),
        .tmode_out (tmode_out)
    );

    // rom word: high half is address bits 10..5, low half is address bits 7..0 xor C3
    function automatic logic [13:0] rom_word(input logic [10:0] a);
        return {a[10:5], a[7:0] ^ 8'hC3};
    endfunction : rom_word

    assign rom_data = rom_word(rom_addr);

    task automatic finish_test();
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge ref_clk);
        bus_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd   <= 1'b0;
        #1;
        chk(what, {8'h00, exp}, {8'h00, bus_rdata});
    endtask : rd

    task automatic op(input op_e k, input logic [5:0] idx, input logic d, input logic [7:0] imm);
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_kind  <= k;
        op_index <= idx;
        op_dest  <= d;
        op_imm   <= imm;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        op_kind  <= OP_NONE;
        #1;
        chk("op_ready", (k == OP_ROM_TABLE_READ) ? 16'h0 : 16'h1, {15'h0, op_ready});
        if (k == OP_ROM_TABLE_READ)
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask : op

    task automatic t_reset();
        chk("tmode_out", 16'h0, {8'h00, tmode_out});
        chk("rom_addr", 16'h0, {5'h00, rom_addr});
        rd(7'h00, 8'h00, "acc");
        rd(7'h01, 8'h00, "status");
        rd(7'h02, 8'h00, "tmode");
        rd(7'h03, 8'h00, "tptr");
        rd(7'h04, 8'h00, "tdata");
        rd(7'h05, 8'h00, "unmapped");
        rd(7'h7F, 8'h00, "reg 63");
        wr(7'h05, 8'hFF);
        rd(7'h05, 8'h00, "unmapped written");
    endtask : t_reset

    task automatic t_sub(input logic [5:0] idx, input logic [7:0] r, input logic [7:0] a,
                         input logic d);
        logic [7:0] diff;
        logic [2:0] fl;
        diff = r - a;
        fl   = {diff == 8'h00, r[3:0] >= a[3:0], r >= a};
        wr({1'b1, idx}, r);
        wr(7'h00, a);
        op(OP_SUB_ACC_FROM_REG, idx, d, 8'h00);
        rd({1'b1, idx}, d ? diff : r, "sub reg");
        rd(7'h00, d ? a : diff, "sub acc");
        rd(7'h01, {5'h00, fl}, "sub flags");
    endtask : t_sub

    task automatic t_swap(input logic d);
        wr(7'h01, 8'h05);
        wr(7'h49, 8'hA5);
        wr(7'h00, 8'h11);
        op(OP_NIBBLE_SWAP_REG, 6'd9, d, 8'h00);
        rd(7'h49, d ? 8'h5A : 8'hA5, "swap reg");
        rd(7'h00, d ? 8'h11 : 8'h5A, "swap acc");
        rd(7'h01, 8'h05, "swap flags");
    endtask : t_swap

    task automatic t_table();
        logic [13:0] w;
        w = rom_word(11'h234);
        wr(7'h03, 8'hFA);
        wr(7'h00, 8'h34);
        wr(7'h01, 8'h06);
        op(OP_ROM_TABLE_READ, 6'd0, 1'b0, 8'h00);
        chk("rom_addr", 16'h0234, {5'h00, rom_addr});
        chk("op_ready after load", 16'h1, {15'h0, op_ready});
        rd(7'h00, w[7:0], "table acc");
        rd(7'h04, {2'b00, w[13:8]}, "table high");
        rd(7'h01, 8'h06, "table flags");
    endtask : t_table

    task automatic t_tmode();
        wr(7'h00, 8'hAA);
        wr(7'h01, 8'h02);
        op(OP_TIMER_MODE_WRITE, 6'd0, 1'b0, 8'h00);
        chk("tmode_out", 16'h00AA, {8'h00, tmode_out});
        rd(7'h02, 8'hAA, "tmode");
        wr(7'h02, 8'h55);
        op(OP_TIMER_MODE_READ, 6'd0, 1'b0, 8'h00);
        rd(7'h00, 8'h55, "tmode read acc");
        rd(7'h01, 8'h02, "tmode flags");
    endtask : t_tmode

    task automatic t_xor_reg(input logic [7:0] r, input logic [7:0] a, input logic d);
        logic [7:0] res;
        res = r ^ a;
        wr(7'h01, 8'h03);
        wr(7'h4C, r);
        wr(7'h00, a);
        op(OP_XOR_ACC_REG, 6'd12, d, 8'h00);
        rd(7'h4C, d ? res : r, "xor reg");
        rd(7'h00, d ? a : res, "xor acc");
        rd(7'h01, {5'h00, res == 8'h00, 2'b11}, "xor flags");
    endtask : t_xor_reg

    task automatic t_xor_imm(input logic [7:0] a, input logic [7:0] imm);
        logic [7:0] res;
        res = a ^ imm;
        wr(7'h01, 8'h03);
        wr(7'h00, a);
        op(OP_XOR_ACC_IMM, 6'd0, 1'b1, imm);
        rd(7'h00, res, "xori acc");
        rd(7'h01, {5'h00, res == 8'h00, 2'b11}, "xori flags");
    endtask : t_xor_imm

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial
    begin
        rst = 1'b1;
        op_valid = 1'b0;
        op_kind = OP_NONE;
        op_index = 6'h00;
        op_dest = 1'b0;
        op_imm = 8'h00;
        bus_addr = 7'h00;
        bus_wdata = 8'h00;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bad_count = 0;
        comparisons = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_sub(6'd5, 8'h05, 8'h06, 1'b1);
        t_sub(6'd63, 8'h06, 8'h06, 1'b0);
        t_sub(6'd0, 8'h06, 8'h05, 1'b1);
        t_sub(6'd17, 8'h80, 8'h0F, 1'b0);
        t_swap(1'b1);
        t_swap(1'b0);
        t_table();
        t_tmode();
        t_xor_reg(8'hA5, 8'hF0, 1'b1);
        t_xor_reg(8'hA5, 8'hA5, 1'b0);
        t_xor_imm(8'hF0, 8'hA5);
        t_xor_imm(8'h55, 8'h55);
        finish_test();
    end

endmodule : tb
